// File: dbpc_top.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "dbpc_map.svh"
module dbpc_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dbpc_pkg::dbpc_link_s link,
   output logic [7:0] bank_open,
   output logic [7:0] bank_closing,
   output logic [1:0] cmd_error
);
   import dbpc_pkg::*;

   dbpc_link_s lk;
   dbpc_cfg_s cfg;
   dbpc_cfg_s next_cfg;
   dbpc_dec_e dec;
   dbpc_dec_e next_dec;
   dbpc_bank_cmd_s bcmd [`DBPC_NBANK];
   logic ck_q;
   logic next_ck_q;
   logic [4:0] op;
   logic [4:0] next_op;
   logic flag;
   logic next_flag;
   logic tick;
   logic issue;
   logic [2:0] bank;
   logic is_col;
   logic [7:0] open_w;
   logic [7:0] closing_w;
   logic [8:0] trpab_eff;
   logic [8:0] rd_delay;
   logic [8:0] wr_delay;
   logic [1:0] err_set;
   logic [1:0] next_err;
   logic [31:0] next_prdata;
   logic [31:0] rd_mux;
   logic next_pready;
   logic next_pslverr;
   logic mapped;
   logic wr_fire;
   logic access;
   logic [2:0] bank_q;

   dbpc_sync #(.W(8)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .din(link),
      .dout(lk)
   );

   // Command decode on link clock rising edges
   assign tick = lk.ck && !ck_q;
   assign issue = tick && (dec == DEC_SECOND);
   assign bank = lk.ca[2:0];
   assign is_col = (op == `DBPC_OP_RD) || (op == `DBPC_OP_WR) || (op == `DBPC_OP_MWR);

   always_comb
   begin
      next_ck_q = lk.ck;
      next_dec = dec;
      next_op = op;
      next_flag = flag;
      unique case (dec)
         DEC_FIRST:
         begin
            if (tick && lk.cs)
            begin
               next_dec = DEC_SECOND;
               next_op = lk.ca[4:0];
               next_flag = lk.ca[`DBPC_FLAG_BIT];
            end
         end
         DEC_SECOND:
         begin
            if (tick)
            begin
               next_dec = DEC_FIRST;
            end
         end
         default:
         begin
            next_dec = DEC_FIRST;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ck_q <= 1'b0;
         dec <= DEC_FIRST;
         op <= 5'h00;
         flag <= 1'b0;
      end
      else
      begin
         ck_q <= next_ck_q;
         dec <= next_dec;
         op <= next_op;
         flag <= next_flag;
      end
   end

   // All-bank interval forced above single-bank interval
   assign trpab_eff = (cfg.trpab > cfg.trppb) ? {1'b0, cfg.trpab} :
      ({1'b0, cfg.trppb} + 9'h001);

   // Read close delay: tRTP, shifted by BL/2-8 for BL32
   assign rd_delay = {1'b0, cfg.nrtp} + (cfg.bl32 ? `DBPC_BL32_RTP_GAP : 9'h000);

   // Write close delay ends on a prefetch group boundary
   assign wr_delay = {1'b0, cfg.wl} + (cfg.bl32 ? `DBPC_HALF_BL32 : `DBPC_HALF_BL16) +
      {1'b0, cfg.nwr} + `DBPC_WR_EXTRA;

   genvar gi;
   generate
      for (gi = 0; gi < `DBPC_NBANK; gi++)
      begin : g_bank
         always_comb
         begin
            bcmd[gi].act = issue && (op == `DBPC_OP_ACT) && (bank == 3'(gi));
            bcmd[gi].pre = issue && (op == `DBPC_OP_PRE) && (flag || bank == 3'(gi));
            bcmd[gi].col = issue && is_col && (bank == 3'(gi));
            bcmd[gi].ap = flag;
            bcmd[gi].trp = (issue && op == `DBPC_OP_PRE && flag) ? trpab_eff :
               {1'b0, cfg.trppb};
            bcmd[gi].ap_delay = (op == `DBPC_OP_RD) ? rd_delay : wr_delay;
         end

         dbpc_bank u_bank
         (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick),
            .cmd(bcmd[gi]),
            .tras(cfg.tras),
            .is_open(open_w[gi]),
            .is_closing(closing_w[gi])
         );
      end
   endgenerate

   // Column to closed bank, or activate to a bank not yet idle
   assign err_set[`DBPC_ERR_COL_BIT] = issue && is_col && !open_w[bank];
   assign err_set[`DBPC_ERR_ACT_BIT] = issue && (op == `DBPC_OP_ACT) &&
      (open_w[bank] || closing_w[bank]);

   // APB slave, one wait state
   assign access = psel && penable && !pready;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `DBPC_OFF_ERR);
   assign wr_fire = psel && penable && pready && pwrite && !pslverr && pstrb[0];

   always_comb
   begin
      unique case (paddr)
         `DBPC_OFF_CTRL: rd_mux = {31'h0, cfg.bl32};
         `DBPC_OFF_TRAS: rd_mux = {24'h0, cfg.tras};
         `DBPC_OFF_TRPPB: rd_mux = {24'h0, cfg.trppb};
         `DBPC_OFF_TRPAB: rd_mux = {24'h0, cfg.trpab};
         `DBPC_OFF_NRTP: rd_mux = {24'h0, cfg.nrtp};
         `DBPC_OFF_WL: rd_mux = {24'h0, cfg.wl};
         `DBPC_OFF_NWR: rd_mux = {24'h0, cfg.nwr};
         `DBPC_OFF_STAT: rd_mux = {16'h0, closing_w, open_w};
         `DBPC_OFF_ERR: rd_mux = {30'h0, cmd_error};
         default: rd_mux = 32'h0;
      endcase
   end

   always_comb
   begin
      next_cfg = cfg;
      next_pready = access;
      next_pslverr = access && !mapped;
      next_prdata = (access && !pwrite && mapped) ? rd_mux : 32'h0;
      next_err = cmd_error;
      if (wr_fire)
      begin
         unique case (paddr)
            `DBPC_OFF_CTRL: next_cfg.bl32 = pwdata[`DBPC_BL32_BIT];
            `DBPC_OFF_TRAS: next_cfg.tras = pwdata[7:0];
            `DBPC_OFF_TRPPB: next_cfg.trppb = pwdata[7:0];
            `DBPC_OFF_TRPAB: next_cfg.trpab = pwdata[7:0];
            `DBPC_OFF_NRTP: next_cfg.nrtp = pwdata[7:0];
            `DBPC_OFF_WL: next_cfg.wl = pwdata[7:0];
            `DBPC_OFF_NWR: next_cfg.nwr = pwdata[7:0];
            `DBPC_OFF_ERR: next_err = cmd_error & ~pwdata[1:0];
            default: next_cfg = cfg;
         endcase
      end
      // New events win over a clear in the same cycle
      next_err = next_err | err_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg <= '{bl32: `DBPC_RST_BL32, tras: `DBPC_RST_TRAS, trppb: `DBPC_RST_TRPPB,
            trpab: `DBPC_RST_TRPAB, nrtp: `DBPC_RST_NRTP, wl: `DBPC_RST_WL,
            nwr: `DBPC_RST_NWR};
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         cmd_error <= 2'b00;
      end
      else
      begin
         cfg <= next_cfg;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
         cmd_error <= next_err;
      end
   end

   // Bank state registered onto the outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bank_open <= 8'h00;
         bank_closing <= 8'h00;
      end
      else
      begin
         bank_open <= open_w;
         bank_closing <= closing_w;
      end
   end

   AST_AB_ALL: assert property (@(posedge pclk) disable iff (!presetn)
      issue && (op == `DBPC_OP_PRE) && flag && (&open_w) |=> ##1 (&bank_closing))
      else $error("all-bank precharge missed a bank");
   AST_ONE_BANK: assert property (@(posedge pclk) disable iff (!presetn)
      issue && (op == `DBPC_OP_PRE) && !flag && (open_w == 8'hFF)
      |=> ##1 (bank_closing == (8'h01 << bank_q)))
      else $error("single-bank precharge hit wrong banks");
   AST_TRPAB_LONGER: assert property (@(posedge pclk) disable iff (!presetn)
      trpab_eff > {1'b0, cfg.trppb})
      else $error("all-bank interval not longer");
   AST_RD16_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg.bl32 |-> rd_delay == {1'b0, cfg.nrtp})
      else $error("BL16 read close delay wrong");
   AST_RD32_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.bl32 |-> rd_delay == {1'b0, cfg.nrtp} + 9'h008)
      else $error("BL32 read close delay wrong");
   AST_WR_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg.bl32 |-> wr_delay == {1'b0, cfg.wl} + {1'b0, cfg.nwr} + 9'h009)
      else $error("write close delay wrong");
   AST_COL_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      issue && is_col && !open_w[bank] |=> cmd_error[0])
      else $error("column to closed bank not flagged");
   AST_ACT_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      issue && (op == `DBPC_OP_ACT) && (open_w[bank] || closing_w[bank])
      |=> cmd_error[1])
      else $error("activate to busy bank not flagged");
   AST_APB_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("APB answer timing wrong");

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bank_q <= 3'h0;
      end
      else if (issue)
      begin
         bank_q <= bank;
      end
   end

   CVR_ALL_PRE: cover property (@(posedge pclk) disable iff (!presetn)
      issue && (op == `DBPC_OP_PRE) && flag);
   CVR_RD_AP: cover property (@(posedge pclk) disable iff (!presetn)
      issue && (op == `DBPC_OP_RD) && flag && open_w[bank]);
   CVR_WR_AP: cover property (@(posedge pclk) disable iff (!presetn)
      issue && (op == `DBPC_OP_WR) && flag && open_w[bank]);
   CVR_ERR_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
      $fell(cmd_error[0]));
endmodule : dbpc_top

// File: dbpc_map.svh
`ifndef DBPC_MAP_SVH
`define DBPC_MAP_SVH

// Register byte offsets
`define DBPC_OFF_CTRL 8'h00
`define DBPC_OFF_TRAS 8'h04
`define DBPC_OFF_TRPPB 8'h08
`define DBPC_OFF_TRPAB 8'h0C
`define DBPC_OFF_NRTP 8'h10
`define DBPC_OFF_WL 8'h14
`define DBPC_OFF_NWR 8'h18
`define DBPC_OFF_STAT 8'h1C
`define DBPC_OFF_ERR 8'h20

// Field positions
`define DBPC_BL32_BIT 0
`define DBPC_FLAG_BIT 5
`define DBPC_ERR_COL_BIT 0
`define DBPC_ERR_ACT_BIT 1

// Reset values, counts in link clock cycles
`define DBPC_RST_BL32 1'b0
`define DBPC_RST_TRAS 8'h06
`define DBPC_RST_TRPPB 8'h04
`define DBPC_RST_TRPAB 8'h06
`define DBPC_RST_NRTP 8'h02
`define DBPC_RST_WL 8'h04
`define DBPC_RST_NWR 8'h06

// First-cycle command codes on ca[4:0]
`define DBPC_OP_ACT 5'h01
`define DBPC_OP_RD 5'h02
`define DBPC_OP_WR 5'h04
`define DBPC_OP_MWR 5'h06
`define DBPC_OP_PRE 5'h10

// Burst timing in link clock cycles, and the bank count
`define DBPC_HALF_BL16 9'h008
`define DBPC_HALF_BL32 9'h010
`define DBPC_BL32_RTP_GAP 9'h008
`define DBPC_WR_EXTRA 9'h001
`define DBPC_NBANK 8

`endif

// File: dbpc_pkg.sv
package dbpc_pkg;

   typedef enum logic [1:0] {DEC_FIRST = 2'b01, DEC_SECOND = 2'b10} dbpc_dec_e;

   typedef enum logic [3:0] {
      BK_IDLE = 4'b0001,
      BK_OPEN = 4'b0010,
      BK_APWAIT = 4'b0100,
      BK_CLOSE = 4'b1000
   } dbpc_bank_e;

   typedef struct packed {
      logic ck;
      logic cs;
      logic [5:0] ca;
   } dbpc_link_s;

   typedef struct packed {
      logic bl32;
      logic [7:0] tras;
      logic [7:0] trppb;
      logic [7:0] trpab;
      logic [7:0] nrtp;
      logic [7:0] wl;
      logic [7:0] nwr;
   } dbpc_cfg_s;

   typedef struct packed {
      logic act;
      logic pre;
      logic col;
      logic ap;
      logic [8:0] trp;
      logic [8:0] ap_delay;
   } dbpc_bank_cmd_s;

endpackage : dbpc_pkg

// File: dbpc_sync.sv
`timescale 1ns/10ps
module dbpc_sync
#(
   parameter int W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_dout;

   // A bit changes only once the second and third stages agree
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         dout <= '0;
      end
      else
      begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         dout <= next_dout;
      end
   end
endmodule : dbpc_sync

// File: dbpc_bank.sv
`timescale 1ns/10ps
module dbpc_bank
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire dbpc_pkg::dbpc_bank_cmd_s cmd,
   input wire logic [7:0] tras,
   output logic is_open,
   output logic is_closing
);
   import dbpc_pkg::*;

   dbpc_bank_e state;
   dbpc_bank_e next_state;
   logic [7:0] ras;
   logic [7:0] next_ras;
   logic [8:0] cnt;
   logic [8:0] next_cnt;

   always_comb
   begin
      next_state = state;
      next_ras = ras;
      next_cnt = cnt;
      if (tick && ras != 8'hFF)
      begin
         next_ras = ras + 8'h01;
      end
      unique case (state)
         BK_IDLE:
         begin
            if (cmd.act)
            begin
               next_state = BK_OPEN;
               next_ras = 8'h00;
            end
         end
         BK_OPEN:
         begin
            if (cmd.pre)
            begin
               next_state = BK_CLOSE;
               next_cnt = cmd.trp;
            end
            else if (cmd.col && cmd.ap)
            begin
               next_state = BK_APWAIT;
               next_cnt = cmd.ap_delay;
            end
         end
         BK_APWAIT:
         begin
            if (tick)
            begin
               if (cnt != 9'h000)
               begin
                  next_cnt = cnt - 9'h001;
               end
               else if (ras >= tras)
               begin
                  next_state = BK_CLOSE;
                  next_cnt = cmd.trp;
               end
            end
         end
         BK_CLOSE:
         begin
            if (tick)
            begin
               if (cnt <= 9'h001)
               begin
                  next_state = BK_IDLE;
               end
               else
               begin
                  next_cnt = cnt - 9'h001;
               end
            end
         end
         default:
         begin
            next_state = BK_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= BK_IDLE;
         ras <= 8'h00;
         cnt <= 9'h000;
      end
      else
      begin
         state <= next_state;
         ras <= next_ras;
         cnt <= next_cnt;
      end
   end

   assign is_open = (state == BK_OPEN) || (state == BK_APWAIT);
   assign is_closing = (state == BK_CLOSE);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_ACT_OPENS: assert property ((state == BK_IDLE) && cmd.act |=> is_open)
      else $error("activate did not open bank");
   AST_PRE_CLOSES: assert property ((state == BK_OPEN) && cmd.pre |=> is_closing && !is_open)
      else $error("precharge did not start closing");
   AST_RAS_LOCK: assert property ((state == BK_CLOSE) && ($past(state) == BK_APWAIT)
      |-> $past(ras) >= $past(tras))
      else $error("auto close before row active time");
   AST_NOAP_OPEN: assert property ((state == BK_OPEN) && cmd.col && !cmd.ap && !cmd.pre
      |=> state == BK_OPEN)
      else $error("plain column command closed bank");
   AST_AP_ENGAGE: assert property ((state == BK_OPEN) && cmd.col && cmd.ap && !cmd.pre
      |=> state == BK_APWAIT)
      else $error("auto close not engaged");
endmodule : dbpc_bank

// File: dbpc_ctrl_model.sv
`timescale 1ns/10ps
module dbpc_ctrl_model
(
   input wire logic pclk,
   output dbpc_pkg::dbpc_link_s link
);
   import dbpc_pkg::*;

   initial link = '0;

   // Half of the 400 ns link period; link clock still between calls
   task automatic half(input logic lvl);
      link.ck <= lvl;
      repeat (4) @(posedge pclk);
   endtask : half

   // Idle link cycles, select low
   task automatic idle(input int n);
      repeat (n)
      begin
         half(1'b1);
         half(1'b0);
      end
   endtask : idle

   // Two-edge command; address lines show the inverse once released
   task automatic send(input logic [4:0] op, input logic flag, input logic [2:0] bank);
      link.cs <= 1'b1;
      link.ca <= {flag, op};
      half(1'b1);
      link.cs <= 1'b0;
      link.ca <= {3'b000, bank};
      half(1'b0);
      half(1'b1);
      link.ca <= ~{3'b000, bank};
      half(1'b0);
   endtask : send
endmodule : dbpc_ctrl_model

// File: tb.sv
`timescale 1ns/10ps
`include "dbpc_map.svh"
module tb;
   import dbpc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr, bank_open, bank_closing;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [1:0] cmd_error;
   dbpc_link_s link;
   int errors, check_count, cycles;
   logic [7:0] offs [9] = '{`DBPC_OFF_CTRL, `DBPC_OFF_TRAS, `DBPC_OFF_TRPPB, `DBPC_OFF_TRPAB,
      `DBPC_OFF_NRTP, `DBPC_OFF_WL, `DBPC_OFF_NWR, `DBPC_OFF_STAT, `DBPC_OFF_ERR};
   logic [7:0] rstv [9] = '{8'h00, `DBPC_RST_TRAS, `DBPC_RST_TRPPB, `DBPC_RST_TRPAB,
      `DBPC_RST_NRTP, `DBPC_RST_WL, `DBPC_RST_NWR, 8'h00, 8'h00};
   logic [4:0] wops [2] = '{`DBPC_OP_WR, `DBPC_OP_MWR};

   dbpc_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link), .bank_open(bank_open),
      .bank_closing(bank_closing), .cmd_error(cmd_error));
   dbpc_ctrl_model ctrl (.pclk(pclk), .link(link));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // Setup, then access held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic bank_chk(input int b, input logic [1:0] exp);
      check({30'h0, bank_open[b], bank_closing[b]}, {30'h0, exp});
   endtask : bank_chk

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         test_done();
      end
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      errors = 0;
      check_count = 0;
      cycles = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (offs[i])
      begin
         apb(1'b0, offs[i], 32'h0);
         check(q, {24'h0, rstv[i]});
      end
      apb(1'b0, 8'h24, 32'h0);
      check({31'h0, e}, 32'h1);
      apb(1'b0, 8'h05, 32'h0);
      check({31'h0, e}, 32'h1);
      apb(1'b1, `DBPC_OFF_STAT, 32'hFFFF);
      apb(1'b0, `DBPC_OFF_STAT, 32'h0);
      check(q, 32'h0);
      // Controller spacing kept by the sequence below
      ctrl.idle(1);
      for (int b = 0; b < 8; b++)
         ctrl.send(`DBPC_OP_ACT, 1'b0, b[2:0]);
      check({24'h0, bank_open}, 32'hFF);
      ctrl.send(`DBPC_OP_PRE, 1'b0, 3'd5);
      check({bank_open, bank_closing}, 32'hDF20);
      ctrl.send(`DBPC_OP_PRE, 1'b1, 3'd5);
      check({bank_open, bank_closing}, 32'h00FF);
      ctrl.idle(4);
      check({24'h0, bank_closing}, 32'hDF);
      ctrl.idle(4);
      check({bank_open, bank_closing}, 32'h0);
      ctrl.send(`DBPC_OP_RD, 1'b0, 3'd0);
      check({30'h0, cmd_error}, 32'h1);
      ctrl.send(`DBPC_OP_ACT, 1'b0, 3'd0);
      ctrl.send(`DBPC_OP_ACT, 1'b0, 3'd0);
      check({30'h0, cmd_error}, 32'h3);
      apb(1'b1, `DBPC_OFF_ERR, 32'h3);
      apb(1'b0, `DBPC_OFF_ERR, 32'h0);
      check(q, 32'h0);
      check({30'h0, cmd_error}, 32'h0);
      ctrl.send(`DBPC_OP_RD, 1'b0, 3'd0);
      ctrl.send(`DBPC_OP_WR, 1'b0, 3'd0);
      ctrl.send(`DBPC_OP_MWR, 1'b0, 3'd0);
      ctrl.idle(25);
      bank_chk(0, 2'b10);
      ctrl.send(`DBPC_OP_ACT, 1'b0, 3'd2);
      ctrl.send(`DBPC_OP_RD, 1'b1, 3'd2);
      ctrl.idle(4);
      bank_chk(2, 2'b10);
      ctrl.idle(1);
      bank_chk(2, 2'b01);
      ctrl.idle(5);
      bank_chk(2, 2'b00);
      apb(1'b1, `DBPC_OFF_CTRL, 32'h1);
      apb(1'b0, `DBPC_OFF_CTRL, 32'h0);
      check(q, 32'h1);
      ctrl.send(`DBPC_OP_ACT, 1'b0, 3'd1);
      ctrl.idle(6);
      ctrl.send(`DBPC_OP_RD, 1'b1, 3'd1);
      ctrl.idle(6);
      bank_chk(1, 2'b10);
      ctrl.idle(6);
      bank_chk(1, 2'b01);
      ctrl.idle(4);
      bank_chk(1, 2'b00);
      apb(1'b1, `DBPC_OFF_CTRL, 32'h0);
      foreach (wops[k])
      begin
         ctrl.send(`DBPC_OP_ACT, 1'b0, 3'(4 + k));
         ctrl.idle(6);
         ctrl.send(wops[k], 1'b1, 3'(4 + k));
         ctrl.idle(16);
         bank_chk(4 + k, 2'b10);
         ctrl.idle(5);
         bank_chk(4 + k, 2'b01);
         ctrl.idle(6);
         bank_chk(4 + k, 2'b00);
      end
      pstrb <= 4'hE;
      apb(1'b1, `DBPC_OFF_TRAS, 32'hFFFFFF01);
      pstrb <= 4'hF;
      apb(1'b0, `DBPC_OFF_TRAS, 32'h0);
      check(q, {24'h0, `DBPC_RST_TRAS});
      apb(1'b1, `DBPC_OFF_TRPAB, 32'hFFFFFF03);
      apb(1'b0, `DBPC_OFF_TRPAB, 32'h0);
      check(q, 32'h3);
      for (int b = 0; b < 8; b++)
         ctrl.send(`DBPC_OP_ACT, 1'b0, b[2:0]);
      check({30'h0, cmd_error}, 32'h2);
      check({bank_open, bank_closing}, 32'hFF00);
      ctrl.send(`DBPC_OP_PRE, 1'b1, 3'd2);
      check({bank_open, bank_closing}, 32'h00FF);
      ctrl.idle(4);
      check({24'h0, bank_closing}, 32'hFF);
      ctrl.idle(1);
      check({bank_open, bank_closing}, 32'h0);
      test_done();
   end
endmodule : tb
